// *** core/sync_serial_engine.sv ***
/*
  8-bit synchronous serial shift engine: transmit, receive and
  full-duplex modes, auto-wait on the internal clock, underrun and
  overrun handling. Assumes a one-cycle register port master on
  ref_clk; sck_in and si are asynchronous and synchronised here.
*/
// Notes on behaviour
// RULE1: underrun sets tx error at shift start; interrupt on next falling clock edge.
// RULE2: serial output stays high while tx error is set.
// RULE3: force stop halts at once, clears start, status and both buffers.
// RULE4: mode 01 selects receive only, 10 selects full duplex.
// RULE5: transfer active rises with a serial clock falling edge after start.
// RULE6: receive samples input on rising edges in selected bit order.
// RULE7: shift active high from first falling edge to eighth rising edge of a byte.
// RULE8: full byte copies to receive buffer, sets full flag, raises interrupt.
// RULE9: internal clock starts within one serial clock period of start.
// RULE10: receive buffer read clears full; transmit buffer write clears empty.
// RULE11: internal clock receive parks clock high until buffer read.
// RULE12: with external clock software reads buffer before next byte completes.
// RULE13: unread buffer at byte end sets rx error and interrupts at once.
// RULE14: while rx error set, incoming data leaves buffer and shifter untouched.
// RULE15: after rx error first read gives old byte, second gives shifter.
// RULE16: rx error clearing after data read also clears the full flag.
// RULE17: after start cleared, reception ends after eight more clock pulses.
// RULE18: uncorrected rx error blocks any further interrupt.
// RULE19: clearing start finishes the byte, drops active, output parks high.
// RULE20: full duplex drives on falling edges, samples on rising, same order.
// RULE21: full duplex internal clock waits for both buffer read and write.
// RULE22: full duplex external clock underrun sets tx error at shift start.
// RULE23: bit order 0 is MSB first, 1 is LSB first, both directions.
// RULE24: mode 00 selects transmit only.
module sync_serial_engine
  import sync_serial_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       sck_in,
  output logic            sck_out,
  output logic            sck_oe,
  input  wire logic       si,
  output logic            so,
  output logic            serial_irq
);

  logic [1:0]   sck_sync_reg;
  logic         sck_prev_reg;
  logic [1:0]   si_sync_reg;
  logic         start_reg;
  logic [1:0]   mode_reg;
  logic         order_reg;
  logic         ext_reg;
  logic [7:0]   transmit_buffer;
  logic [7:0]   receive_buffer;
  logic [7:0]   shift_reg;
  logic         active_reg;
  logic         shift_flag_reg;
  logic         tx_empty_reg;
  logic         rx_full_reg;
  logic         tx_err_reg;
  logic         rx_err_reg;
  logic         err_read_reg;
  logic         irq_pend_reg;
  logic [2:0]   bit_cnt_reg;
  logic [HALF_CNT_W-1:0] half_cnt_reg;
  shift_state_t state_reg;

  logic wr_ctrl, wr_tx, rd_rx, force_stop;
  logic tx_mode, rx_mode, may_start, run_clk;
  logic fall_ev, rise_ev, byte_start, byte_done;
  logic rx_err_set, raise_irq;
  logic [7:0] shift_next;

  assign wr_ctrl    = reg_wr && (reg_addr == CTRL_OFFS);
  assign wr_tx      = reg_wr && (reg_addr == TXBUF_OFFS);
  assign rd_rx      = reg_rd && (reg_addr == RXBUF_OFFS);
  assign force_stop = wr_ctrl && reg_wdata[CTRL_STOP_BIT];

  assign tx_mode = (mode_reg == MODE_TX) || (mode_reg == MODE_TXRX); // [RULE4] [RULE24]
  assign rx_mode = (mode_reg == MODE_RX) || (mode_reg == MODE_TXRX); // [RULE4]

  // auto-wait gate at a byte boundary for the internal clock
  always_comb begin
    case (mode_reg)
      MODE_TX:   may_start = !tx_empty_reg;
      MODE_RX:   may_start = !rx_full_reg;                  // [RULE11]
      MODE_TXRX: may_start = !tx_empty_reg && !rx_full_reg; // [RULE21]
      default:   may_start = 1'b0;
    endcase
  end

  assign run_clk = !ext_reg && ((state_reg == ST_SHIFT) || (start_reg && may_start));

  // edge events: external from the synchronised pin, internal from the divider
  always_comb begin
    if (ext_reg) begin
      fall_ev = sck_prev_reg && !sck_sync_reg[1];
      rise_ev = !sck_prev_reg && sck_sync_reg[1];
    end else begin
      fall_ev = run_clk && (half_cnt_reg == HALF_LAST) && sck_out;
      rise_ev = run_clk && (half_cnt_reg == HALF_LAST) && !sck_out;
    end
  end

  // an external transfer still marked active runs one more byte after start is cleared
  assign byte_start = fall_ev && (state_reg == ST_IDLE) &&
                      (start_reg || (ext_reg && active_reg));             // [RULE5] [RULE17]
  // next shifter value; the byte-end copy needs the eighth bit as well
  assign shift_next = order_reg ? {si_sync_reg[1], shift_reg[7:1]}
                                : {shift_reg[6:0], si_sync_reg[1]};       // [RULE6] [RULE23]
  assign byte_done  = rise_ev && (state_reg == ST_SHIFT) && (bit_cnt_reg == BITCNT_END);
  assign rx_err_set = byte_done && rx_mode && rx_full_reg && !rx_err_reg; // [RULE13]
  // once rx error stands, nothing raises the interrupt again
  assign raise_irq  = !rx_err_reg && (rx_err_set ||                       // [RULE18]
                      (byte_done && rx_mode && !rx_full_reg) ||          // [RULE8]
                      (fall_ev && irq_pend_reg));                        // [RULE1]

  // pin synchronisers; first stage feeds only the second
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sck_sync_reg <= 2'h3;
      sck_prev_reg <= 1'b1;
      si_sync_reg  <= 2'h3;
    end else begin
      sck_sync_reg <= {sck_sync_reg[0], sck_in};
      sck_prev_reg <= sck_sync_reg[1];
      si_sync_reg  <= {si_sync_reg[0], si};
    end
  end

  // control register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      start_reg <= 1'b0;
      mode_reg  <= MODE_RST;
      order_reg <= 1'b0;
      ext_reg   <= 1'b0;
    end else if (force_stop) begin
      start_reg <= 1'b0; // [RULE3]
    end else if (wr_ctrl) begin
      start_reg <= reg_wdata[CTRL_START_BIT];
      mode_reg  <= reg_wdata[CTRL_MODE_LSB +: 2];
      order_reg <= reg_wdata[CTRL_ORDER_BIT];
      ext_reg   <= reg_wdata[CTRL_EXT_BIT];
    end
  end

  // internal serial clock divider; parks high between bytes
  always_ff @(posedge ref_clk) begin
    if (sys_rst || force_stop || !run_clk) begin
      half_cnt_reg <= '0;
      sck_out      <= 1'b1; // [RULE11] [RULE21]
    end else if (half_cnt_reg == HALF_LAST) begin
      half_cnt_reg <= '0;
      sck_out      <= !sck_out; // [RULE9]
    end else begin
      half_cnt_reg <= half_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sck_oe <= 1'b0;
    end else begin
      sck_oe <= !ext_reg;
    end
  end

  // byte sequencer
  always_ff @(posedge ref_clk) begin
    if (sys_rst || force_stop) begin
      state_reg      <= ST_IDLE;
      bit_cnt_reg    <= BITCNT_RST;
      active_reg     <= 1'b0;
      shift_flag_reg <= 1'b0;
    end else if (byte_start) begin
      state_reg      <= ST_SHIFT;
      bit_cnt_reg    <= BITCNT_RST;
      active_reg     <= 1'b1; // [RULE5]
      shift_flag_reg <= 1'b1; // [RULE7]
    end else if (byte_done) begin
      state_reg      <= ST_IDLE;
      shift_flag_reg <= 1'b0; // [RULE7]
      // with start cleared the byte still runs out its eight pulses
      if (!start_reg) begin
        active_reg <= 1'b0; // [RULE17] [RULE19]
      end
    end else if (rise_ev && (state_reg == ST_SHIFT)) begin
      bit_cnt_reg <= bit_cnt_reg + 1'b1;
    end else if (!ext_reg && !start_reg && (state_reg == ST_IDLE)) begin
      active_reg <= 1'b0; // [RULE19]
    end
  end

  // shifter: load on first fall from a full transmit buffer, sample on each rise while rx error is clear
  always_ff @(posedge ref_clk) begin
    if (sys_rst || force_stop) begin
      shift_reg <= BYTE_RST;
    end else if (byte_start && tx_mode && !tx_empty_reg) begin
      shift_reg <= transmit_buffer;
    end else if (rise_ev && (state_reg == ST_SHIFT) && !rx_err_reg) begin // [RULE14]
      shift_reg <= shift_next; // [RULE6] [RULE23]
    end
  end

  // serial output, driven on falling edges; forced high at byte end and while tx error is set
  always_ff @(posedge ref_clk) begin
    if (sys_rst || force_stop) begin
      so <= 1'b1;
    end else if (tx_err_reg || (byte_start && tx_mode && tx_empty_reg)) begin
      so <= 1'b1; // [RULE2]
    end else if (byte_start && tx_mode) begin
      so <= order_reg ? transmit_buffer[0] : transmit_buffer[7]; // [RULE20] [RULE23]
    end else if (fall_ev && (state_reg == ST_SHIFT) && tx_mode) begin
      so <= order_reg ? shift_reg[0] : shift_reg[7]; // [RULE20]
    end else if (byte_done) begin
      so <= 1'b1; // [RULE19]
    end
  end

  // transmit buffer and its empty flag
  always_ff @(posedge ref_clk) begin
    if (sys_rst || force_stop) begin
      transmit_buffer <= BYTE_RST;
      tx_empty_reg    <= 1'b1; // [RULE3]
    end else begin
      if (wr_tx) begin
        transmit_buffer <= reg_wdata;
      end
      // a load in the write cycle wins: the flag reads empty again
      if (byte_start && tx_mode && !tx_empty_reg) begin
        tx_empty_reg <= 1'b1;
      end else if (wr_tx) begin
        tx_empty_reg <= 1'b0; // [RULE10]
      end
    end
  end

  // underrun flag and the deferred interrupt
  always_ff @(posedge ref_clk) begin
    if (sys_rst || force_stop) begin
      tx_err_reg   <= 1'b0; // [RULE3]
      irq_pend_reg <= 1'b0;
    end else begin
      if (byte_start && tx_mode && tx_empty_reg) begin
        tx_err_reg   <= 1'b1; // [RULE1] [RULE22]
        irq_pend_reg <= 1'b1; // [RULE1]
      end else if (fall_ev) begin
        irq_pend_reg <= 1'b0;
      end
    end
  end

  // receive buffer, full and overrun flags
  always_ff @(posedge ref_clk) begin
    if (sys_rst || force_stop) begin
      receive_buffer <= BYTE_RST;
      rx_full_reg    <= 1'b0; // [RULE3]
      rx_err_reg     <= 1'b0;
      err_read_reg   <= 1'b0;
    end else begin
      if (byte_done && rx_mode && !rx_full_reg && !rx_err_reg) begin
        receive_buffer <= shift_next; // [RULE8]
      end
      if (rx_err_set) begin
        rx_err_reg <= 1'b1; // [RULE13]
      end else if (rd_rx && rx_err_reg && err_read_reg) begin
        rx_err_reg   <= 1'b0;
        err_read_reg <= 1'b0;
      end else if (rd_rx && rx_err_reg) begin
        err_read_reg <= 1'b1; // [RULE15]
      end
      // set beats a clearing read in the same cycle
      if (byte_done && rx_mode && !rx_err_reg) begin
        rx_full_reg <= 1'b1; // [RULE8]
      end else if (rd_rx && rx_err_reg && err_read_reg) begin
        rx_full_reg <= 1'b0; // [RULE16]
      end else if (rd_rx && !rx_err_reg) begin
        rx_full_reg <= 1'b0; // [RULE10]
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst || force_stop) begin
      serial_irq <= 1'b0;
    end else begin
      serial_irq <= raise_irq;
    end
  end

  // read port: data one cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      reg_rdata <= BYTE_RST;
    end else if (reg_rd) begin
      reg_rdata <= BYTE_RST;
      case (reg_addr)
        CTRL_OFFS: begin
          reg_rdata[CTRL_START_BIT]       <= start_reg;
          reg_rdata[CTRL_MODE_LSB +: 2]   <= mode_reg;
          reg_rdata[CTRL_ORDER_BIT]       <= order_reg;
          reg_rdata[CTRL_EXT_BIT]         <= ext_reg;
        end
        STATUS_OFFS: begin
          reg_rdata[STAT_ACTIVE_BIT] <= active_reg;
          reg_rdata[STAT_SHIFT_BIT]  <= shift_flag_reg;
          reg_rdata[STAT_TXEMP_BIT]  <= tx_empty_reg;
          reg_rdata[STAT_RXFULL_BIT] <= rx_full_reg;
          reg_rdata[STAT_TX_UNDERRUN_FLAG_BIT]  <= tx_err_reg;
          reg_rdata[STAT_RX_OVERRUN_FLAG_BIT]  <= rx_err_reg;
        end
        TXBUF_OFFS: reg_rdata <= transmit_buffer;
        RXBUF_OFFS: begin
          // second read after an overrun shows the held shifter
          reg_rdata <= (rx_err_reg && err_read_reg) ? shift_reg : receive_buffer; // [RULE15]
        end
        default: reg_rdata <= BYTE_RST;
      endcase
    end
  end

endmodule : sync_serial_engine

// *** pkg/sync_serial_pkg.sv ***
/*
  Constants, register map and state type for the synchronous serial
  shift engine. Assumes a 200 MHz ref_clk and an 8-bit register port.
*/
package sync_serial_pkg;

  // timing: internal serial clock half period
  localparam int CLK_PERIOD_NS = 5;
  localparam int SCK_HALF_NS   = 80;
  localparam int SCK_HALF_CYC  = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HALF_CNT_W    = 5;
  localparam logic [HALF_CNT_W-1:0] HALF_LAST = HALF_CNT_W'(SCK_HALF_CYC - 1);

  // register offsets
  localparam logic [1:0] CTRL_OFFS   = 2'h0;
  localparam logic [1:0] STATUS_OFFS = 2'h1;
  localparam logic [1:0] TXBUF_OFFS  = 2'h2;
  localparam logic [1:0] RXBUF_OFFS  = 2'h3;

  // serial_control_reg fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_STOP_BIT  = 1;
  localparam int CTRL_MODE_LSB  = 2;
  localparam int CTRL_ORDER_BIT = 4;
  localparam int CTRL_EXT_BIT   = 5;

  // serial_status_reg fields
  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_SHIFT_BIT  = 1;
  localparam int STAT_TXEMP_BIT  = 2;
  localparam int STAT_RXFULL_BIT = 3;
  localparam int STAT_TX_UNDERRUN_FLAG_BIT  = 4;
  localparam int STAT_RX_OVERRUN_FLAG_BIT  = 5;

  // transfer mode field encodings
  localparam logic [1:0] MODE_TX   = 2'h0;
  localparam logic [1:0] MODE_RX   = 2'h1;
  localparam logic [1:0] MODE_TXRX = 2'h2;

  // reset values and the last bit count
  localparam logic [7:0] BYTE_RST   = 8'h00;
  localparam logic [1:0] MODE_RST   = 2'h0;
  localparam logic [2:0] BITCNT_RST = 3'h0;
  localparam logic [2:0] BITCNT_END = 3'h7;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_SHIFT = 2'b10
  } shift_state_t;

endpackage : sync_serial_pkg

// *** verif/sync_serial_monitor.sv ***
/*
  Port checker for the serial engine.
  Assumes ref_clk rising edge sampling and sys_rst synchronous, active high.
*/
module sync_serial_monitor
  import sync_serial_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       sys_rst,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       sck_in,
  input wire logic       sck_out,
  input wire logic       sck_oe,
  input wire logic       si,
  input wire logic       so,
  input wire logic       serial_irq
);
  logic [1:0] mode_reg;
  logic       fresh_reg;
  logic [4:0] lo_cnt;

  // force stop writes leave the mode field alone
  always_ff @(posedge ref_clk) begin
    if (sys_rst) mode_reg <= MODE_RST;
    else if (reg_wr && reg_addr == CTRL_OFFS && !reg_wdata[CTRL_STOP_BIT]) mode_reg <= reg_wdata[CTRL_MODE_LSB +: 2];
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) fresh_reg <= 1'b1;
    else if (reg_wr) fresh_reg <= 1'b0;
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst || sck_out) lo_cnt <= 5'h00;
    else lo_cnt <= lo_cnt + 5'h01;
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  chk_reset_idle: assert property (disable iff (1'b0) sys_rst |=> sck_out && so && !sck_oe && !serial_irq)
    else $error("outputs not idle after reset");
  chk_irq_single: assert property (serial_irq |=> !serial_irq)
    else $error("interrupt longer than one cycle");
  chk_sck_half: assert property ($rose(sck_out) |-> lo_cnt == 5'(SCK_HALF_CYC))
    else $error("serial clock low phase has wrong length");
  chk_sck_idle: assert property (!sck_oe |-> sck_out)
    else $error("serial clock not parked high");
  chk_rx_so_high: assert property (mode_reg == MODE_RX && $past(mode_reg) == MODE_RX |-> so)
    else $error("data output moved in receive mode");
  chk_so_low_hold: assert property (sck_oe && !sck_out && $past(sck_out) == 1'b0 && $past(sck_out, 2) == 1'b0
    |-> $stable(so))
    else $error("data output changed inside low phase");
  chk_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data changed without a read");
  chk_status_reset: assert property (reg_rd && reg_addr == STATUS_OFFS && fresh_reg |=> reg_rdata == 8'h04)
    else $error("status reset value wrong");

  cov_irq: cover property (serial_irq);
  cov_sck_rise: cover property ($rose(sck_out));
  cov_so_fall: cover property ($fell(so));
endmodule : sync_serial_monitor

bind sync_serial_engine sync_serial_monitor u_sync_serial_monitor (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe), .si(si), .so(so), .serial_irq(serial_irq));

// *** verif/serial_peer.sv ***
/*
  Behavioural serial peer: drives si on falling line-clock edges, captures so on rising ones.
  Assumes the bench loads tx_sh and clears bits before each byte.
*/
module serial_peer (
  input  wire logic sck_line,
  input  wire logic so,
  input  wire logic lsb,
  output logic      si
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] tx_sh;
  logic [7:0] rx_sh;
  int         bits;
  initial si = 1'b1;
  always @(negedge sck_line) begin
    si <= lsb ? tx_sh[0] : tx_sh[7];
    tx_sh <= lsb ? {1'b0, tx_sh[7:1]} : {tx_sh[6:0], 1'b0};
  end
  // after a byte the line is released: flip it late so no stale bit can pass
  always @(posedge sck_line) begin
    rx_sh <= lsb ? {so, rx_sh[7:1]} : {rx_sh[6:0], so};
    bits <= bits + 1;
    if (bits % 8 == 7) si <= #40 ~si;
  end
endmodule : serial_peer

// *** verif/tb.sv ***
/*
  Self-checking bench for the serial engine with a behavioural peer.
  Assumes a 200 MHz ref_clk and a 160 ns external serial clock.
*/
module tb;
  import sync_serial_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic       ref_clk, sys_rst, reg_wr, reg_rd, peer_sck, lsb;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata, rdat;
  wire  [7:0] reg_rdata;
  wire        sck_out, sck_oe, so, serial_irq, si, sck_line;
  int         n_fail, num_checks, irq_cnt, s;

  assign sck_line = sck_oe ? sck_out : peer_sck;
  sync_serial_engine u_sync_serial_engine (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sck_in(sck_line),
    .sck_out(sck_out), .sck_oe(sck_oe), .si(si), .so(so), .serial_irq(serial_irq));
  serial_peer u_serial_peer (.sck_line(sck_line), .so(so), .lsb(lsb), .si(si));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (serial_irq === 1'b1) irq_cnt <= irq_cnt + 1;

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [1:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rdat = reg_rdata;
  endtask : rd
  task load(input logic [7:0] b);
    u_serial_peer.tx_sh = b;
    u_serial_peer.bits = 0;
  endtask : load
  // the peer clock is free of ref_clk phase on purpose
  task ext_byte(input logic [7:0] b);
    load(b);
    #1.3;
    repeat (8) begin
      #80 peer_sck = 1'b0;
      #80 peer_sck = 1'b1;
    end
    #200;
  endtask : ext_byte
  task wait_irq();
    repeat (800) if (irq_cnt == s) @(posedge ref_clk);
    chk({7'h0, irq_cnt > s}, 8'h01);
  endtask : wait_irq

  task t_reset();
    rd(STATUS_OFFS);
    chk(rdat, 8'h04);
    rd(RXBUF_OFFS);
    chk(rdat, 8'h00);
  endtask : t_reset
  task t_int_txrx();
    load(8'h5a);
    wr(TXBUF_OFFS, 8'ha5);
    s = irq_cnt;
    wr(CTRL_OFFS, 8'h09);
    wait_irq();
    rd(RXBUF_OFFS);
    chk(rdat, 8'h5a);
    chk(u_serial_peer.rx_sh, 8'ha5);
    rd(STATUS_OFFS);
    chk(rdat, 8'h05);
    repeat (80) @(posedge ref_clk);
    chk({7'h0, sck_out}, 8'h01);
    wr(CTRL_OFFS, 8'h02);
  endtask : t_int_txrx
  task t_ext_overrun();
    lsb = 1'b1;
    wr(CTRL_OFFS, 8'h35);
    s = irq_cnt;
    ext_byte(8'h3c);
    wait_irq();
    s = irq_cnt;
    ext_byte(8'hc3);
    wait_irq();
    rd(STATUS_OFFS);
    chk(rdat & 8'h28, 8'h28);
    s = irq_cnt;
    ext_byte(8'h55);
    chk(8'(irq_cnt - s), 8'h00);
    wr(CTRL_OFFS, 8'h34);
    rd(RXBUF_OFFS);
    chk(rdat, 8'h3c);
    rd(RXBUF_OFFS);
    chk(rdat, 8'hc3);
    rd(STATUS_OFFS);
    chk(rdat & 8'h28, 8'h00);
    ext_byte(8'h00);
    rd(STATUS_OFFS);
    chk(rdat & 8'h01, 8'h00);
  endtask : t_ext_overrun
  task t_ext_underrun();
    wr(CTRL_OFFS, 8'h02);
    lsb = 1'b0;
    wr(CTRL_OFFS, 8'h29);
    s = irq_cnt;
    ext_byte(8'h0f);
    rd(STATUS_OFFS);
    chk(rdat & 8'h10, 8'h10);
    chk(u_serial_peer.rx_sh, 8'hff);
    chk({7'h0, irq_cnt > s}, 8'h01);
    wr(CTRL_OFFS, 8'h02);
    rd(STATUS_OFFS);
    chk(rdat, 8'h04);
    rd(RXBUF_OFFS);
    chk(rdat, 8'h00);
  endtask : t_ext_underrun
  task t_int_rx();
    load(8'h96);
    s = irq_cnt;
    wr(CTRL_OFFS, 8'h05);
    wait_irq();
    repeat (60) @(posedge ref_clk);
    chk({7'h0, sck_out}, 8'h01);
    rd(RXBUF_OFFS);
    chk(rdat, 8'h96);
    s = irq_cnt;
    repeat (60) if (sck_out === 1'b1) @(posedge ref_clk);
    chk({7'h0, sck_out}, 8'h00);
    wait_irq();
    wr(CTRL_OFFS, 8'h02);
  endtask : t_int_rx

  task results();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results

  initial begin
    #200000;
    n_fail++;
    results();
  end
  initial begin
    {sys_rst, reg_wr, reg_rd, peer_sck, lsb} = 5'b10010;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    {n_fail, num_checks, irq_cnt} = '0;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_int_txrx();
    t_ext_overrun();
    t_ext_underrun();
    t_int_rx();
    results();
  end
endmodule : tb
